// *** hdl/ext_irq_edge_detect.sv ***
// External interrupt request input stage: filters, edge selection and register slave
`timescale 1ns/100ps
`include "ext_irq_defines.svh"

module ext_irq_edge_detect
    import ext_irq_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int NPINS = 10
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request pins
    input wire logic nmi_pin,
    input wire logic [8:0] ext_request_pins,
    input wire logic sub_clock_tick,
    input wire logic main_clock_halted,
    // Requests to the interrupt controller
    output logic nmi_request,
    output logic [8:0] ext_request,
    output logic stop_release,
    output logic standby_release
);

    localparam logic [2:0] ANALOG_CYC = 3'(`ANALOG_DELAY_CYC);
    localparam int PIN3 = 4;

    typedef struct packed {
        edge_regs_t regs;
        logic [NPINS-1:0] level;
        logic [NPINS-1:0][2:0] persist;
        logic [2:0] samples;
        logic [9:0] div_cnt;
        logic [NPINS-1:0] req;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        bus_phase_t wr_phase;
        logic [1:0] bresp;
        bus_phase_t rd_phase;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t st;
    state_t next_st;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
        logic [11:0] idx;
        idx = addr[13:2];
        case (idx)
            12'(`IDX_FALL_A): decode = 4'h1;
            12'(`IDX_RISE_A): decode = 4'h2;
            12'(`IDX_FALL_B): decode = 4'h3;
            12'(`IDX_RISE_B): decode = 4'h4;
            12'(`IDX_FALL_C): decode = 4'h5;
            12'(`IDX_RISE_C): decode = 4'h6;
            12'(`IDX_FALL_D_HIGH): decode = 4'h7;
            12'(`IDX_RISE_D_HIGH): decode = 4'h8;
            12'(`IDX_FILTER_CTL): decode = 4'h9;
            default: decode = 4'h0;
        endcase
    endfunction : decode

    function automatic logic [7:0] read_reg(input edge_regs_t r, input logic [3:0] sel);
        case (sel)
            4'h1: read_reg = r.fall_a;
            4'h2: read_reg = r.rise_a;
            4'h3: read_reg = r.fall_b;
            4'h4: read_reg = r.rise_b;
            4'h5: read_reg = r.fall_c;
            4'h6: read_reg = r.rise_c;
            4'h7: read_reg = r.fall_d;
            4'h8: read_reg = r.rise_d;
            4'h9: read_reg = r.filter_ctl;
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // Byte write on lane 0, or masked bit write: lane 1 names the bits touched
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] strb, input logic [7:0] impl);
        logic [7:0] touched;
        touched = strb[1] ? d[15:8] : (strb[0] ? 8'hff : 8'h00);
        merge = ((old & ~touched) | (d[7:0] & touched)) & impl; // [RQ7]
    endfunction : merge

    // Returns {fall, rise} enables of a pin: 0 nmi, 1..9 pins 0..8
    function automatic logic [1:0] pin_enables(input edge_regs_t r, input int p);
        logic [1:0] e;
        e = 2'b00;
        if (p == 0)
            e = {r.fall_a[`BIT_NMI_A], r.rise_a[`BIT_NMI_A]}; // [RQ3]
        else if (p <= 4)
            e = {r.fall_a[`BIT_PIN0_A + p - 1], r.rise_a[`BIT_PIN0_A + p - 1]}; // [RQ3]
        else if (p <= 7)
            e = {r.fall_d[`BIT_PIN4_D + p - 5], r.rise_d[`BIT_PIN4_D + p - 5]}; // [RQ6]
        else if (p == 8)
            e = {r.fall_b[`BIT_PIN7_B], r.rise_b[`BIT_PIN7_B]}; // [RQ4]
        else
            e = {r.fall_c[`BIT_PIN8_C], r.rise_c[`BIT_PIN8_C]}; // [RQ5]
        pin_enables = e;
    endfunction : pin_enables

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [NPINS-1:0] raw;
    logic sample_tick;
    logic [9:0] div_mask;
    logic digital;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic do_write;
    logic [NPINS-1:0] new_level;

    assign raw = {ext_request_pins, nmi_pin};
    assign digital = st.regs.filter_ctl[`BIT_DIGITAL_EN]; // [RQ10] [RQ19]

    always_comb
    begin
        next_st = st;
        new_level = st.level;
        wsel = decode(st.awaddr);
        rsel = decode(s_axi_araddr);
        do_write = 1'b0;
        div_mask = 10'h000;
        sample_tick = 1'b0;

        // Divider stands still while the main clock is halted in standby
        if (!main_clock_halted)
            next_st.div_cnt = st.div_cnt + 10'h001;
        if (st.regs.filter_ctl[2:0] < `SEL_SUB_CLOCK)
        begin
            div_mask = 10'((11'h001 << (`DIV_MIN_LOG2 + st.regs.filter_ctl[2:0])) - 11'h001); // [RQ11]
            sample_tick = !main_clock_halted && ((st.div_cnt & div_mask) == div_mask); // [RQ14]
        end
        else if (st.regs.filter_ctl[2:0] == `SEL_SUB_CLOCK)
            sample_tick = sub_clock_tick; // [RQ11] [RQ14]

        // Delay filter: level follows the pin only after it persisted
        for (int p = 0; p < NPINS; p++)
        begin
            if (raw[p] == st.level[p])
                next_st.persist[p] = 3'h0;
            else if (st.persist[p] == ANALOG_CYC - 3'h1)
            begin
                next_st.persist[p] = 3'h0;
                new_level[p] = raw[p]; // [RQ8]
            end
            else
                next_st.persist[p] = st.persist[p] + 3'h1;
        end

        // Three-sample filter on pin 3; refills over three ticks after a change
        if (sample_tick)
            next_st.samples = {st.samples[1:0], raw[PIN3]}; // [RQ12] [RQ13]
        if (digital)
        begin
            new_level[PIN3] = st.level[PIN3];
            if (st.samples == 3'b111)
                new_level[PIN3] = 1'b1; // [RQ12] [RQ20]
            else if (st.samples == 3'b000)
                new_level[PIN3] = 1'b0; // [RQ12] [RQ20]
        end
        next_st.level = new_level;

        // Edge selection and one-cycle request pulses
        for (int p = 0; p < NPINS; p++)
        begin
            logic [1:0] en;
            en = pin_enables(st.regs, p);
            next_st.req[p] = (en[0] && !st.level[p] && new_level[p]) ||
                             (en[1] && st.level[p] && !new_level[p]); // [RQ1] [RQ21]
        end

        // Write channel: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        case (st.wr_phase)
            BUS_IDLE:
            begin
                if (st.aw_got && st.w_got)
                begin
                    next_st.aw_got = 1'b0;
                    next_st.w_got = 1'b0;
                    next_st.wr_phase = BUS_RESP;
                    next_st.bresp = 2'b00;
                    if (wsel == 4'h0)
                        next_st.bresp = 2'b11;
                    else if (wsel == 4'h9 && st.wstrb[1])
                        next_st.bresp = 2'b10; // [RQ18]
                    else
                        do_write = 1'b1;
                end
            end
            BUS_RESP:
            begin
                if (s_axi_bready)
                    next_st.wr_phase = BUS_IDLE;
            end
            default: next_st.wr_phase = BUS_IDLE;
        endcase
        if (do_write)
        begin
            case (wsel)
                4'h1: next_st.regs.fall_a = merge(st.regs.fall_a, st.wdata, st.wstrb, `MASK_GROUP_A);
                4'h2: next_st.regs.rise_a = merge(st.regs.rise_a, st.wdata, st.wstrb, `MASK_GROUP_A);
                4'h3: next_st.regs.fall_b = merge(st.regs.fall_b, st.wdata, st.wstrb, `MASK_GROUP_B);
                4'h4: next_st.regs.rise_b = merge(st.regs.rise_b, st.wdata, st.wstrb, `MASK_GROUP_B);
                4'h5: next_st.regs.fall_c = merge(st.regs.fall_c, st.wdata, st.wstrb, `MASK_GROUP_C);
                4'h6: next_st.regs.rise_c = merge(st.regs.rise_c, st.wdata, st.wstrb, `MASK_GROUP_C);
                4'h7: next_st.regs.fall_d = merge(st.regs.fall_d, st.wdata, st.wstrb, `MASK_GROUP_D);
                4'h8: next_st.regs.rise_d = merge(st.regs.rise_d, st.wdata, st.wstrb, `MASK_GROUP_D);
                4'h9:
                begin
                    if (st.wstrb[0])
                        next_st.regs.filter_ctl = st.wdata[7:0] & `MASK_FILTER_CTL; // [RQ18]
                end
                default: next_st.regs = st.regs;
            endcase
        end

        // Read channel: whole registers, unused bits zero
        case (st.rd_phase)
            BUS_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    next_st.rd_phase = BUS_RESP;
                    next_st.rdata = read_reg(st.regs, rsel); // [RQ3] [RQ4] [RQ6]
                    next_st.rresp = (rsel == 4'h0) ? 2'b11 : 2'b00;
                end
            end
            BUS_RESP:
            begin
                if (s_axi_rready)
                    next_st.rd_phase = BUS_IDLE;
            end
            default: next_st.rd_phase = BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.regs <= '{default: `RESET_VALUE}; // [RQ2] [RQ5] [RQ18]
            st.wr_phase <= BUS_IDLE;
            st.rd_phase <= BUS_IDLE;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = !st.aw_got && st.wr_phase == BUS_IDLE;
    assign s_axi_wready = !st.w_got && st.wr_phase == BUS_IDLE;
    assign s_axi_bvalid = st.wr_phase == BUS_RESP;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.rd_phase == BUS_IDLE;
    assign s_axi_rvalid = st.rd_phase == BUS_RESP;
    assign s_axi_rdata = {24'h000000, st.rdata};
    assign s_axi_rresp = st.rresp;

    assign nmi_request = st.req[0]; // [RQ2]
    assign ext_request = st.req[NPINS-1:1];

    // Pin-to-output path with no clocked element so stop mode can be left
    always_comb
    begin
        logic [1:0] nmi_en;
        nmi_en = pin_enables(st.regs, 0);
        stop_release = (nmi_en[0] && !st.level[0] && nmi_pin) ||
                       (nmi_en[1] && st.level[0] && !nmi_pin); // [RQ9]
    end

    // Digital pin 3 only counts while its sampling clock still runs
    assign standby_release = stop_release || (|st.req[NPINS-1:1]); // [RQ14]

endmodule : ext_irq_edge_detect

// *** hdl/ext_irq_defines.svh ***
// Offsets, field layout, reset values and timing counts of the external request input stage
//
// Overview of operation
// [RQ1] Per pin falling/rising enable pair: 00 none, 01 rising, 10 falling, 11 both.
// [RQ2] All edge enable registers reset to zero; the non-maskable pin raises nothing.
// [RQ3] Group a: bit 2 non-maskable pin, bits 3-6 pins 0-3, others read zero.
// [RQ4] Group b: bit 1 selects edges of pin 7 only, other bits zero.
// [RQ5] Group c: bit 0 selects edges of pin 8, both registers reset zero.
// [RQ6] Group d high: positions 13-15 control pins 4-6, positions 8-12 read zero.
// [RQ7] Edge enable registers accept whole-byte and single-bit writes.
// [RQ8] Every request input passes a minimum-persistence delay filter before edge detection; the code bypasses it for pin 3 while digital enable is set.
// [RQ9] A valid non-maskable edge releases stop mode without relying on the clock.
// [RQ10] Filter control: bit 7 digital enable for pin 3, bits 2-0 sample clock.
// [RQ11] Sample clock is main clock divided by 64 to 1024, or the subclock.
// [RQ12] Digital filter takes three samples and accepts a level when all agree.
// [RQ13] After a sample clock change the filter settles over three samples.
// [RQ14] Digital pin 3 wakes standby only while its sampling clock runs.
// [RQ15] Software clears a pin's enables before switching it to port use.
// [RQ16] Software keeps enables zero for pins not used as request inputs.
// [RQ17] Software keeps serial receive and edge detection apart on pins 7, 8.
// [RQ18] Filter control register is whole-byte access only and resets to zero.
// [RQ19] Enable 0 selects 60 ns analog filter; codes 000-101 valid, others prohibited.
// [RQ20] Digital filter rejects noise up to two sample clocks wide.
// [RQ21] Filtered level compared with previous value gives a one-cycle request pulse.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_FILTER_CTL 32'hfffff318
`define IDX_FALL_A 32'hfffffc00
`define IDX_FALL_B 32'hfffffc06
`define IDX_FALL_C 32'hfffffc10
`define IDX_FALL_D_HIGH 32'hfffffc13
`define IDX_RISE_A 32'hfffffc20
`define IDX_RISE_B 32'hfffffc26
`define IDX_RISE_C 32'hfffffc30
`define IDX_RISE_D_HIGH 32'hfffffc33

// ----------------------------------------
// Implemented bits and reset values
// ----------------------------------------
`define MASK_GROUP_A 8'h7c
`define MASK_GROUP_B 8'h02
`define MASK_GROUP_C 8'h01
`define MASK_GROUP_D 8'he0
`define MASK_FILTER_CTL 8'h87
`define RESET_VALUE 8'h00
`define BIT_NMI_A 2
`define BIT_PIN0_A 3
`define BIT_PIN7_B 1
`define BIT_PIN8_C 0
`define BIT_PIN4_D 5
`define BIT_DIGITAL_EN 7
`define SEL_SUB_CLOCK 3'h5
`define SAMPLE_COUNT 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define ANALOG_DELAY_NS 60
`define ANALOG_DELAY_CYC ((`ANALOG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_MIN_LOG2 6

`endif

// *** hdl/ext_irq_pkg.sv ***
// Types of the external request input stage
package ext_irq_pkg;

    typedef struct packed {
        logic [7:0] fall_a;
        logic [7:0] rise_a;
        logic [7:0] fall_b;
        logic [7:0] rise_b;
        logic [7:0] fall_c;
        logic [7:0] rise_c;
        logic [7:0] fall_d;
        logic [7:0] rise_d;
        logic [7:0] filter_ctl;
    } edge_regs_t;

    typedef enum {
        BUS_IDLE,
        BUS_RESP
    } bus_phase_t;

endpackage : ext_irq_pkg

// *** dv/ext_irq_properties.sv ***
// Port-level checker of the external request input stage
`timescale 1ns/100ps
module ext_irq_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Pins and requests
    input wire logic [8:0] ext_request_pins,
    input wire logic [8:0] ext_request,
    input wire logic nmi_request,
    input wire logic stop_release,
    input wire logic standby_release
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late or read not refused");
    request_pulse_a: assert property (|ext_request |=> (ext_request & $past(ext_request)) == 9'h000)
        else $error("request longer than one cycle");
    nmi_pulse_a: assert property (nmi_request |=> !nmi_request)
        else $error("non-maskable request longer than one cycle");
    // Pin 0 is always analog: six stable samples must precede its request
    analog_persist_a: assert property (ext_request[0] |->
        $past(ext_request_pins[0], 1) == $past(ext_request_pins[0], 6) &&
        $past(ext_request_pins[0], 6) != $past(ext_request_pins[0], 7))
        else $error("request on pin 0 without persistent level");
    standby_or_a: assert property (standby_release == (stop_release || (|ext_request)))
        else $error("standby release not tied to its causes");
endmodule : ext_irq_properties

bind ext_irq_edge_detect ext_irq_properties u_props (.ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ext_request_pins, .ext_request, .nmi_request, .stop_release,
    .standby_release);

// *** dv/ext_pin_source.sv ***
// Behavioural model of the sources driving the request pins
`timescale 1ns/100ps
module ext_pin_source (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Commanded levels, bit 9 is the non-maskable pin
    input wire logic [9:0] level_cmd,
    input wire logic [7:0] tick_period,
    // Pins
    output logic nmi_pin,
    output logic [8:0] ext_request_pins,
    output logic sub_clock_tick
);
    logic [7:0] tick_cnt;

    // Subclock oscillator runs free; pins move just after an edge
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {nmi_pin, ext_request_pins} <= 10'h000;
            tick_cnt <= 8'h00;
            sub_clock_tick <= 1'b0;
        end
        else
        begin
            {nmi_pin, ext_request_pins} <= level_cmd;
            tick_cnt <= (tick_cnt == tick_period) ? 8'h00 : tick_cnt + 8'h01;
            sub_clock_tick <= (tick_cnt == tick_period);
        end
    end
endmodule : ext_pin_source

// *** dv/ext_irq_edge_detect_tb.sv ***
// Self-checking testbench of the external request input stage
`timescale 1ns/100ps
module ext_irq_edge_detect_tb;
    // Fall a,b,c,d then rise a,b,c,d; pin k sits in group P_GRP, bit P_BIT (9 is non-maskable)
    localparam logic [13:0] A_EDGE [8] = '{14'h3000, 14'h3018, 14'h3040, 14'h304c, 14'h3080, 14'h3098, 14'h30c0, 14'h30cc};
    localparam logic [7:0] M_EDGE [4] = '{8'h7c, 8'h02, 8'h01, 8'he0};
    localparam int P_GRP [10] = '{0, 0, 0, 0, 3, 3, 3, 1, 2, 0};
    localparam int P_BIT [10] = '{3, 4, 5, 6, 5, 6, 7, 1, 0, 2};
    localparam logic [13:0] A_FLT = 14'h0c60;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, main_clock_halted = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic nmi_pin, sub_clock_tick, nmi_request, stop_release, standby_release;
    logic [8:0] ext_request_pins, ext_request;
    logic [9:0] level_cmd = 10'h000;
    logic [7:0] tick_period = 8'h13;
    int n_fail = 0, checked = 0, cycles = 0;

    ext_irq_edge_detect u_dut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .nmi_pin, .ext_request_pins, .sub_clock_tick, .main_clock_halted, .nmi_request,
        .ext_request, .stop_release, .standby_release);
    ext_pin_source u_src (.ref_clk, .reset_n, .level_cmd, .tick_period, .nmi_pin, .ext_request_pins,
        .sub_clock_tick);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check
    task automatic axi_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge ref_clk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask : axi_write
    task automatic rd_chk(input string what, input logic [13:0] a, input logic [7:0] exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        check(what, {24'h0, exp}, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd_chk
    // Bit write: change mask in wdata[15:8], new values in wdata[7:0]
    task automatic set_mode(input int k, input logic [1:0] m);
        logic [7:0] b = 8'h01 << P_BIT[k];
        axi_write(A_EDGE[P_GRP[k]], {16'h0, b, m[1] ? b : 8'h00}, 4'h2);
        axi_write(A_EDGE[P_GRP[k] + 4], {16'h0, b, m[0] ? b : 8'h00}, 4'h2);
    endtask : set_mode
    // Cycle of the first request pulse after a pin move, 0 if none
    task automatic pin_move(input int k, input logic v, input int win, output int seen);
        logic [9:0] nv = level_cmd;
        logic [9:0] req;
        seen = 0;
        nv[k] = v;
        level_cmd <= nv;
        for (int i = 1; i <= win; i++)
        begin
            @(negedge ref_clk);
            req = {nmi_request, ext_request};
            if (req[k] === 1'b1 && seen == 0)
                seen = i;
        end
        @(posedge ref_clk);
    endtask : pin_move
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_registers();
        for (int i = 0; i < 8; i++)
        begin
            rd_chk("edge reset", A_EDGE[i], 8'h00, 2'b00);
            axi_write(A_EDGE[i], 32'hff, 4'h1);
            rd_chk("edge mask", A_EDGE[i], M_EDGE[i % 4], 2'b00);
            axi_write(A_EDGE[i], 32'h0, 4'h1);
        end
        axi_write(A_EDGE[0], 32'h74, 4'h1);
        axi_write(A_EDGE[0], 32'h0c08, 4'h2);
        rd_chk("bit write", A_EDGE[0], 8'h78, 2'b00);
        axi_write(A_EDGE[0], 32'h0, 4'h1);
        rd_chk("filter reset", A_FLT, 8'h00, 2'b00);
        for (int c = 0; c < 6; c++)
        begin
            axi_write(A_FLT, 32'h80 | c, 4'h1);
            rd_chk("sample select", A_FLT, 8'h80 | 8'(c), 2'b00);
        end
        axi_write(A_FLT, 32'hff, 4'h1);
        rd_chk("filter mask", A_FLT, 8'h87, 2'b00);
        axi_write(A_FLT, 32'h8000, 4'h2);
        check("filter bit write", 2'b10, rsp);
        rd_chk("filter kept", A_FLT, 8'h87, 2'b00);
        axi_write(A_FLT, 32'h0, 4'h1);
        axi_write(14'h0ffc, 32'hff, 4'h1);
        check("unmapped write", 2'b11, rsp);
        rd_chk("unmapped read", 14'h0ffc, 8'h00, 2'b11);
    endtask : test_registers
    task automatic test_pins();
        int s;
        for (int k = 0; k < 10; k++)
        begin
            set_mode(k, 2'b01);
            pin_move(k, 1'b1, 12, s);
            check("rise latency", 8, s);
            set_mode(k, 2'b00);
            pin_move(k, 1'b0, 12, s);
            check("disabled pin", 0, s);
        end
        for (int m = 0; m < 4; m++)
        begin
            set_mode(0, m[1:0]);
            pin_move(0, 1'b1, 12, s);
            check("rise mode", m[0] ? 8 : 0, s);
            pin_move(0, 1'b0, 12, s);
            check("fall mode", m[1] ? 8 : 0, s);
        end
        pin_move(0, 1'b1, 5, s);
        pin_move(0, 1'b0, 14, s);
        check("short pulse", 0, s);
        set_mode(0, 2'b00);
        set_mode(9, 2'b01);
        level_cmd <= 10'h200;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("stop release", 1'b1, stop_release);
        check("standby release", 1'b1, standby_release);
        repeat (10) @(negedge ref_clk);
        check("release settles", 1'b0, stop_release);
        @(posedge ref_clk);
        set_mode(9, 2'b00);
        pin_move(9, 1'b0, 12, s);
    endtask : test_pins
    task automatic test_digital();
        int s;
        axi_write(A_FLT, 32'h85, 4'h1);
        repeat (60) @(posedge ref_clk);
        set_mode(3, 2'b11);
        pin_move(3, 1'b1, 30, s);
        check("noise rise", 0, s);
        pin_move(3, 1'b0, 100, s);
        check("noise fall", 0, s);
        pin_move(3, 1'b1, 100, s);
        check("three samples", 1'b1, s >= 41 && s <= 66);
        axi_write(A_FLT, 32'h80, 4'h1);
        main_clock_halted <= 1'b1;
        pin_move(3, 1'b0, 250, s);
        check("halted clock", 0, s);
        main_clock_halted <= 1'b0;
        pin_move(3, 1'b0, 250, s);
        check("divided clock", 1'b1, s > 0);
        set_mode(3, 2'b00);
        axi_write(A_FLT, 32'h0, 4'h1);
    endtask : test_digital
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        test_registers();
        test_pins();
        test_digital();
        tally_and_finish();
    end
endmodule : ext_irq_edge_detect_tb
